// ===== rshc_pkg.sv
// package: constants, types and behaviour summary for the reset source and halt control block
// Behaviour
// - deep sleep plus low reset pin resets system
// - pin reset in deep sleep sets external flag
// - nine low bit times request debug reset
// - low stop bit requests debug reset
// - transmit collision requests debug reset
// - debug reset spares the debug unit
// - debug reset from deep sleep sets power-on flag
// - read-only cause register collects reset source flags until a read clears them
// - reading cause register clears upper four bits
// - cause reads and watchdog writes share address
// - halt instruction stops core and program counter
// - clocks and peripherals keep running in halt
// - watchdog oscillator and counter run in halt
// - interrupt, watchdog, power, brown-out, pin leave halt
// - each power control bit disables one peripheral
package rshc_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  localparam int unsigned GLITCH_MIN_PS   = 12000;
  // least time rounds up, never below one cycle
  localparam int unsigned GLITCH_CYC_RAW  = (GLITCH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GLITCH_CYCLES   = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
  localparam int unsigned BREAK_BITS      = 9;
  localparam int unsigned BIT_TIME_CYCLES = 16;
  localparam int unsigned CHAR_DATA_BITS  = 8;
  // cause register field positions
  localparam int unsigned CAUSE_POR_BIT   = 7;
  localparam int unsigned CAUSE_STOP_BIT  = 6;
  localparam int unsigned CAUSE_WDT_BIT   = 5;
  localparam int unsigned CAUSE_PIN_BIT   = 4;
  localparam logic [7:0]  CAUSE_RST_VAL   = 8'h80;
  localparam logic [7:0]  CAUSE_LOW_MASK  = 8'h0F;
  localparam logic [7:0]  WDT_CTL_RST_VAL = 8'h00;

  typedef enum logic [1:0]
  {
    PM_RUN  = 2'b00,
    PM_HALT = 2'b01,
    PM_STOP = 2'b10
  } rshc_pmode_t;
endpackage : rshc_pkg

// ===== rshc_pin_filter.sv
// glitch filter for the active-low external reset pin
`timescale 1ns/1ps
`default_nettype none
module rshc_pin_filter
  import rshc_pkg::*;
#(
  parameter int unsigned MIN_CYCLES = GLITCH_CYCLES
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // pin and qualified level
  input  wire logic pin_n,
  output var  logic low_seen
);
  localparam int unsigned CW = $clog2(MIN_CYCLES + 2);
  localparam logic [CW-1:0] LIMIT = CW'(MIN_CYCLES);

  initial
  begin
    if (MIN_CYCLES < 1) $error("filter needs at least one cycle");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  assign nxt_cnt  = pin_n ? '0 : ((cnt_ff > LIMIT) ? cnt_ff : cnt_ff + CW'(1));

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) cnt_ff <= '0;
    else     cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) low_seen <= 1'b0;
    else     low_seen <= !pin_n && (cnt_ff >= LIMIT);
  end
endmodule : rshc_pin_filter
`default_nettype wire

// ===== rshc_debug_mon.sv
// debug pin monitor: break, framing error and collision detection
`timescale 1ns/1ps
`default_nettype none
module rshc_debug_mon
  import rshc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_TIME_CYCLES,
  parameter int unsigned DATA_BITS  = CHAR_DATA_BITS
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // debug pin, three signals
  input  wire logic debug_serial_pin_i,
  input  wire logic debug_serial_pin_o,
  input  wire logic debug_serial_pin_oe,
  // request
  output var  logic debug_rst_req
);
  localparam int unsigned BRK_CYC = BREAK_BITS * BIT_CYCLES;
  localparam int unsigned CW      = $clog2(BRK_CYC + 2);
  localparam int unsigned BW      = $clog2(DATA_BITS + 2);

  initial
  begin
    if (BIT_CYCLES < 2 || DATA_BITS < 1) $error("bad debug pin parameters");
  end

  logic [CW-1:0] low_cnt_ff;
  logic [CW-1:0] bit_cnt_ff;
  logic [BW-1:0] bits_ff;
  logic          busy_ff;
  logic          prev_ff;
  logic          mid_bit;
  logic          start_edge;
  logic          brk_hit;
  logic          frame_hit;
  logic          coll_hit;

  assign start_edge = !busy_ff && prev_ff && !debug_serial_pin_i;
  assign mid_bit    = busy_ff && (bit_cnt_ff == CW'(BIT_CYCLES / 2));
  assign brk_hit    = (low_cnt_ff == CW'(BRK_CYC - 1)) && !debug_serial_pin_i;
  assign frame_hit  = mid_bit && (bits_ff == BW'(DATA_BITS + 1)) && !debug_serial_pin_i;
  assign coll_hit   = debug_serial_pin_oe && (debug_serial_pin_o != debug_serial_pin_i);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      low_cnt_ff <= '0;
      bit_cnt_ff <= '0;
      bits_ff    <= '0;
      busy_ff    <= 1'b0;
      prev_ff    <= 1'b1;
      debug_rst_req <= 1'b0;
    end
    else
    begin
      prev_ff       <= debug_serial_pin_i;
      debug_rst_req <= brk_hit || frame_hit || coll_hit;
      low_cnt_ff    <= debug_serial_pin_i ? '0 : (brk_hit ? '0 : low_cnt_ff + CW'(1));
      if (start_edge)
      begin
        busy_ff    <= 1'b1;
        bit_cnt_ff <= '0;
        bits_ff    <= '0;
      end
      else if (busy_ff)
      begin
        bit_cnt_ff <= (bit_cnt_ff == CW'(BIT_CYCLES - 1)) ? '0 : bit_cnt_ff + CW'(1);
        if (mid_bit)
        begin
          bits_ff <= bits_ff + BW'(1);
          if (bits_ff == BW'(DATA_BITS + 1)) busy_ff <= 1'b0;
        end
      end
    end
  end
endmodule : rshc_debug_mon
`default_nettype wire

// ===== rshc_top.sv
// reset source recording, halt and stop control and peripheral gating
`timescale 1ns/1ps
`default_nettype none
module rshc_top
  import rshc_pkg::*;
#(
  parameter int unsigned PERIPH_COUNT = 8,
  parameter int unsigned BIT_CYCLES   = BIT_TIME_CYCLES
)
(
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // reset and wake sources
  input  wire logic                    reset_pin_n,
  input  wire logic                    por_event,
  input  wire logic                    brownout_event,
  input  wire logic                    wdt_timeout,
  input  wire logic                    wdt_timeout_is_rst,
  input  wire logic                    irq_pending,
  // core instruction events
  input  wire logic                    halt_exec,
  input  wire logic                    stop_exec,
  // debug pin
  input  wire logic                    debug_serial_pin_i,
  input  wire logic                    debug_serial_pin_o,
  input  wire logic                    debug_serial_pin_oe,
  // shared status/watchdog control access
  input  wire logic                    cause_rd,
  input  wire logic                    cause_wr,
  input  wire logic [7:0]              cause_wdata,
  output var  logic [7:0]              reset_cause_status,
  output var  logic [7:0]              wdt_ctl,
  // power control
  input  wire logic [PERIPH_COUNT-1:0] periph_disable,
  output var  logic [PERIPH_COUNT-1:0] periph_clk_en,
  // mode and reset outputs
  output var  logic                    sys_rst,
  output var  logic                    core_run,
  output var  logic                    pc_advance_en,
  output var  logic                    sys_clk_en,
  output var  logic                    osc_en,
  output var  logic                    wdt_osc_en,
  output var  logic                    in_halt,
  output var  logic                    in_stop
);
  initial
  begin
    if (PERIPH_COUNT < 1) $error("need at least one peripheral");
  end

  rshc_pmode_t   mode_ff;
  rshc_pmode_t   nxt_mode;
  logic          pin_low;
  logic          debug_req;
  logic          stop_pin_rst;
  logic          stop_debug_rst;
  logic          any_rst;
  logic          halt_exit;
  logic [7:0]    nxt_cause;
  logic [7:0]    set_bits;

  rshc_pin_filter #(
    .MIN_CYCLES (GLITCH_CYCLES)
  ) u_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_n    (reset_pin_n),
    .low_seen (pin_low)
  );

  // debug unit keeps its own state; only rst clears it
  rshc_debug_mon #(
    .BIT_CYCLES (BIT_CYCLES),
    .DATA_BITS  (CHAR_DATA_BITS)
  ) u_debug (
    .core_clk            (core_clk),
    .rst                 (rst),
    .debug_serial_pin_i  (debug_serial_pin_i),
    .debug_serial_pin_o  (debug_serial_pin_o),
    .debug_serial_pin_oe (debug_serial_pin_oe),
    .debug_rst_req       (debug_req)
  );

  // pin reset out of deep sleep
  assign stop_pin_rst = (mode_ff == PM_STOP) && pin_low;
  assign stop_debug_rst = (mode_ff == PM_STOP) && debug_req;
  assign any_rst      = pin_low || debug_req || por_event || brownout_event || (wdt_timeout && wdt_timeout_is_rst);
  assign halt_exit    = irq_pending || wdt_timeout || por_event || brownout_event || pin_low;

  always_comb
  begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      PM_RUN:
      begin
        if (stop_exec) nxt_mode = PM_STOP;
        else if (halt_exec) nxt_mode = PM_HALT;
      end
      PM_HALT:
      begin
        if (halt_exit || any_rst) nxt_mode = PM_RUN;
      end
      PM_STOP:
      begin
        if (any_rst) nxt_mode = PM_RUN;
      end
      default:   nxt_mode = PM_RUN;
    endcase
  end

  // cause flags, set wins over the read clear
  always_comb
  begin
    set_bits = 8'h00;
    set_bits[CAUSE_PIN_BIT]  = stop_pin_rst || (pin_low && mode_ff != PM_STOP);
    set_bits[CAUSE_STOP_BIT] = stop_pin_rst || stop_debug_rst;
    set_bits[CAUSE_POR_BIT]  = stop_debug_rst || por_event || brownout_event;
    set_bits[CAUSE_WDT_BIT]  = wdt_timeout;
  end

  assign nxt_cause = ((cause_rd ? (reset_cause_status & CAUSE_LOW_MASK) : reset_cause_status)) | set_bits;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) mode_ff <= PM_RUN;
    else     mode_ff <= nxt_mode;
  end

  // read-only cause register, no write path
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) reset_cause_status <= CAUSE_RST_VAL;
    else     reset_cause_status <= nxt_cause;
  end

  // writes at the shared address reach watchdog control
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)           wdt_ctl <= WDT_CTL_RST_VAL;
    else if (cause_wr) wdt_ctl <= cause_wdata;
  end

  // system reset pulse, debug unit excluded
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) sys_rst <= 1'b1;
    else     sys_rst <= any_rst;
  end

  // core and pc stop in halt and stop
  assign core_run      = (mode_ff == PM_RUN);
  assign pc_advance_en = (mode_ff == PM_RUN);
  assign sys_clk_en    = (mode_ff != PM_STOP);
  assign osc_en        = (mode_ff != PM_STOP);
  assign wdt_osc_en    = 1'b1;
  assign in_halt       = (mode_ff == PM_HALT);
  assign in_stop       = (mode_ff == PM_STOP);
  assign periph_clk_en = sys_clk_en ? ~periph_disable : '0;
endmodule : rshc_top
`default_nettype wire

// ===== rshc_checker.sv
// assertion checker for the reset source and halt control block
`timescale 1ns/1ps
`default_nettype none
module rshc_checker
  import rshc_pkg::*;
#(
  parameter int unsigned PERIPH_COUNT = 8,
  parameter int unsigned BIT_CYCLES   = BIT_TIME_CYCLES
)
(
  // clock and reset
  input wire logic                    core_clk, rst,
  // events
  input wire logic                    reset_pin_n, por_event, brownout_event, wdt_timeout, irq_pending,
  input wire logic                    halt_exec, cause_rd,
  // debug pin
  input wire logic                    debug_serial_pin_i, debug_serial_pin_o, debug_serial_pin_oe,
  // outputs
  input wire logic [7:0]              reset_cause_status,
  input wire logic [PERIPH_COUNT-1:0] periph_disable, periph_clk_en,
  input wire logic                    sys_rst, core_run, pc_advance_en, sys_clk_en, osc_en, wdt_osc_en,
  input wire logic                    in_halt, in_stop
);
  logic [15:0] low_cnt_ff;
  wire quiet = reset_pin_n & ~(irq_pending | wdt_timeout | por_event | brownout_event);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // counter avoids a long repetition on the break length
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      low_cnt_ff <= 16'h0;
    else if (debug_serial_pin_i)
      low_cnt_ff <= 16'h0;
    else if (low_cnt_ff != 16'hFFFF)
      low_cnt_ff <= low_cnt_ff + 16'h1;
  AST_PIN_RST: assert property (!reset_pin_n [*2] |-> ##[0:3] sys_rst)
    else $error("pin low two cycles without system reset");
  AST_EXT_FLAG: assert property (!reset_pin_n [*2] |-> ##[0:3] reset_cause_status[CAUSE_PIN_BIT])
    else $error("external pin flag not set");
  AST_BREAK: assert property (low_cnt_ff == BREAK_BITS*BIT_CYCLES |-> ##[0:6] sys_rst)
    else $error("break without system reset");
  AST_COLL: assert property (debug_serial_pin_oe && debug_serial_pin_o != debug_serial_pin_i
    |-> ##[1:4] sys_rst)
    else $error("collision without system reset");
  AST_LOW_ZERO: assert property (reset_cause_status[3:0] == 4'h0)
    else $error("low cause bits not zero");
  AST_RD_CLR: assert property (cause_rd && !wdt_timeout ##1 !sys_rst |-> reset_cause_status[7:4] == 4'h0)
    else $error("read did not clear cause bits");
  AST_HALT: assert property (halt_exec && quiet && !in_halt && !in_stop |=> in_halt && !core_run
    && !pc_advance_en)
    else $error("halt entry wrong");
  AST_HALT_RUN: assert property (in_halt |-> sys_clk_en && osc_en && wdt_osc_en)
    else $error("clock stopped in halt");
  // a one-cycle pin glitch is filtered, so only a qualified low must end halt
  AST_HALT_EXIT: assert property (in_halt && (irq_pending | wdt_timeout | por_event | brownout_event)
    |-> ##[1:4] !in_halt)
    else $error("halt not left");
  AST_HALT_PIN: assert property ((in_halt && !reset_pin_n) [*2] |-> ##[1:3] !in_halt)
    else $error("halt not left on pin reset");
  AST_GATE: assert property (!in_stop |-> periph_clk_en == ~periph_disable)
    else $error("peripheral gating wrong");
  COV_HALT: cover property (in_halt ##1 !in_halt);
  COV_STOP_RST: cover property (in_stop ##1 sys_rst);
  COV_POR_FLAG: cover property (sys_rst && reset_cause_status[CAUSE_POR_BIT]);
endmodule : rshc_checker
bind rshc_top rshc_checker #(.PERIPH_COUNT(PERIPH_COUNT), .BIT_CYCLES(BIT_CYCLES)) u_chk (
  .core_clk (core_clk), .rst (rst), .reset_pin_n (reset_pin_n), .por_event (por_event),
  .brownout_event (brownout_event), .wdt_timeout (wdt_timeout), .irq_pending (irq_pending),
  .halt_exec (halt_exec), .cause_rd (cause_rd), .debug_serial_pin_i (debug_serial_pin_i),
  .debug_serial_pin_o (debug_serial_pin_o), .debug_serial_pin_oe (debug_serial_pin_oe),
  .reset_cause_status (reset_cause_status), .periph_disable (periph_disable), .periph_clk_en (periph_clk_en),
  .sys_rst (sys_rst), .core_run (core_run), .pc_advance_en (pc_advance_en), .sys_clk_en (sys_clk_en),
  .osc_en (osc_en), .wdt_osc_en (wdt_osc_en), .in_halt (in_halt), .in_stop (in_stop)
);
`default_nettype wire

// ===== rshc_dbg_host.sv
// serial debug host model on the shared pulled-up debug line
`timescale 1ns/1ps
`default_nettype none
module rshc_dbg_host
#(
  parameter int unsigned BIT_CYCLES = 4
)
(
  // clock
  input  wire logic core_clk,
  // device drive
  input  wire logic dev_o,
  input  wire logic dev_oe,
  // resolved line
  output var  logic line
);
  logic host_ff = 1'h1;
  // either party pulls the line low
  always_comb line = host_ff & (dev_oe ? dev_o : 1'h1);
  task automatic hold(input logic lvl, input int n);
    host_ff = lvl;
    repeat (n) @(negedge core_clk);
  endtask : hold
  task automatic send_char(input logic [7:0] d, input logic stp);
    hold(1'h0, BIT_CYCLES);
    for (int i = 0; i < 8; i++)
      hold(d[i], BIT_CYCLES);
    hold(stp, BIT_CYCLES);
    hold(1'h1, 2*BIT_CYCLES);
  endtask : send_char
endmodule : rshc_dbg_host
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the reset source and halt control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rshc_pkg::*;
;
  localparam int BC = 4;
  logic core_clk = 1'h0, rst = 1'h1, reset_pin_n = 1'h1, por_event = 1'h0, brownout_event = 1'h0;
  logic wdt_timeout = 1'h0, wdt_timeout_is_rst = 1'h0, irq_pending = 1'h0, halt_exec = 1'h0, stop_exec = 1'h0;
  logic debug_serial_pin_i, debug_serial_pin_o = 1'h1, debug_serial_pin_oe = 1'h0, cause_rd = 1'h0, cause_wr = 1'h0;
  logic [7:0] cause_wdata = 8'h00, reset_cause_status, wdt_ctl, periph_disable = 8'hA5, periph_clk_en;
  logic sys_rst, core_run, pc_advance_en, sys_clk_en, osc_en, wdt_osc_en, in_halt, in_stop;
  int miscompares = 0;
  int compares = 0;
  always #12.5 core_clk = ~core_clk;
  rshc_top #(.PERIPH_COUNT(8), .BIT_CYCLES(BC)) DUT (
    .core_clk (core_clk), .rst (rst), .reset_pin_n (reset_pin_n), .por_event (por_event),
    .brownout_event (brownout_event), .wdt_timeout (wdt_timeout), .wdt_timeout_is_rst (wdt_timeout_is_rst),
    .irq_pending (irq_pending), .halt_exec (halt_exec), .stop_exec (stop_exec),
    .debug_serial_pin_i (debug_serial_pin_i), .debug_serial_pin_o (debug_serial_pin_o),
    .debug_serial_pin_oe (debug_serial_pin_oe), .cause_rd (cause_rd), .cause_wr (cause_wr),
    .cause_wdata (cause_wdata), .reset_cause_status (reset_cause_status), .wdt_ctl (wdt_ctl),
    .periph_disable (periph_disable), .periph_clk_en (periph_clk_en), .sys_rst (sys_rst), .core_run (core_run),
    .pc_advance_en (pc_advance_en), .sys_clk_en (sys_clk_en), .osc_en (osc_en), .wdt_osc_en (wdt_osc_en),
    .in_halt (in_halt), .in_stop (in_stop)
  );
  rshc_dbg_host #(.BIT_CYCLES(BC)) host (.core_clk (core_clk), .dev_o (debug_serial_pin_o),
    .dev_oe (debug_serial_pin_oe), .line (debug_serial_pin_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pulse
  // a system reset may come anywhere inside the window
  task automatic see_rst(input int n, input logic exp);
    logic seen;
    seen = 1'h0;
    repeat (n)
    begin
      @(negedge core_clk);
      seen = seen | sys_rst;
    end
    chk(seen, exp);
  endtask : see_rst
  task automatic t_regs();
    chk(reset_cause_status, CAUSE_RST_VAL);
    chk(wdt_ctl, WDT_CTL_RST_VAL);
    pulse(cause_rd);
    chk(reset_cause_status, 8'h00);
    cause_wdata = 8'h3C;
    pulse(cause_wr);
    chk(wdt_ctl, 8'h3C);
    chk(reset_cause_status, 8'h00);
  endtask : t_regs
  task automatic t_pin();
    pulse(stop_exec);
    reset_pin_n = 1'h0;
    cyc(1);
    reset_pin_n = 1'h1;
    see_rst(6, 1'h0);
    chk(in_stop, 1'h1);
    reset_pin_n = 1'h0;
    see_rst(5, 1'h1);
    reset_pin_n = 1'h1;
    cyc(2);
    chk(reset_cause_status, 8'h50);
    chk(in_stop, 1'h0);
    pulse(cause_rd);
  endtask : t_pin
  task automatic t_halt();
    logic [7:0] exp_cause [6] = '{8'h00, 8'h20, 8'h80, 8'h80, 8'h10, 8'h20};
    for (int k = 0; k < 6; k++)
    begin
      // last pass makes the time-out a reset
      wdt_timeout_is_rst = (k == 5);
      pulse(halt_exec);
      chk({in_halt, core_run, pc_advance_en}, 8'h04);
      chk({sys_clk_en, osc_en, wdt_osc_en}, 8'h07);
      chk(periph_clk_en, 8'h5A);
      case (k)
        0: irq_pending = 1'h1;
        1, 5: wdt_timeout = 1'h1;
        2: por_event = 1'h1;
        3: brownout_event = 1'h1;
        default: reset_pin_n = 1'h0;
      endcase
      see_rst(3, k >= 2);
      {irq_pending, wdt_timeout, por_event, brownout_event, reset_pin_n} = 5'h01;
      cyc(4);
      chk(in_halt, 1'h0);
      chk(reset_cause_status, exp_cause[k]);
      pulse(cause_rd);
    end
  endtask : t_halt
  task automatic t_debug();
    pulse(stop_exec);
    fork
      host.hold(1'h0, 10*BC);
      see_rst(9*BC+2, 1'h1);
    join
    host.hold(1'h1, 4);
    chk(reset_cause_status, 8'hC0);
    pulse(cause_rd);
    pulse(stop_exec);
    fork
      host.send_char(8'hA5, 1'h0);
      see_rst(12*BC, 1'h1);
    join
    chk(reset_cause_status, 8'hC0);
    fork
      host.send_char(8'h55, 1'h1);
      see_rst(12*BC, 1'h0);
    join
    debug_serial_pin_oe = 1'h1;
    fork
      host.hold(1'h0, 2);
      see_rst(6, 1'h1);
    join
    host.hold(1'h1, 0);
    debug_serial_pin_oe = 1'h0;
  endtask : t_debug
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial
  begin
    #100us;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    cyc(16);
    rst = 1'h0;
    cyc(2);
    t_regs();
    t_pin();
    t_halt();
    t_debug();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
